/* hdl/rtc_ctrl_pkg.sv */
// package: register map, field positions, reset values and carrier types of the rtc control slice
package rtc_ctrl_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [4:0] IDX_FORMAT_WAKEUP = 5'h08;
  localparam logic [4:0] IDX_ENABLE        = 5'h09;
  localparam logic [4:0] IDX_OUTPUT_HOUR   = 5'h0A;
  localparam logic [4:0] IDX_INIT_STATUS   = 5'h0C;
  localparam logic [4:0] IDX_EVENT_FLAG    = 5'h0D;
  localparam logic [4:0] IDX_SYNC_DIV_HIGH = 5'h10;
  localparam logic [4:0] IDX_CALIB_LOW     = 5'h13;
  localparam logic [4:0] IDX_SHIFT_LOW     = 5'h1B;

  // reset values
  localparam logic [7:0] RST_FORMAT_WAKEUP = 8'h00;
  localparam logic [7:0] RST_ENABLE        = 8'h00;
  localparam logic [7:0] RST_OUTPUT_HOUR   = 8'h00;
  localparam logic [7:0] RST_EVENT_FLAG    = 8'h00;
  localparam logic [6:0] RST_SYNC_DIV_HIGH = 7'h00;

  // field positions shared by the control registers
  localparam int BIT_HOUR_FORMAT  = 6;
  localparam int BIT_RATIO        = 5;
  localparam int BIT_BYPASS       = 4;
  localparam int BIT_WAKEUP_IE    = 6;
  localparam int BIT_ALARM_IE     = 4;
  localparam int BIT_WAKEUP_EN    = 2;
  localparam int BIT_ALARM_EN     = 0;
  localparam int BIT_CAL_OUT_EN   = 7;
  localparam int BIT_POLARITY     = 4;
  localparam int BIT_CAL_FREQ     = 3;
  localparam int BIT_DST_MEMO     = 2;
  localparam int BIT_SUB_HOUR     = 1;
  localparam int BIT_ADD_HOUR     = 0;
  localparam int BIT_INIT         = 7;
  localparam int BIT_SHADOW_SYNC  = 5;

  // alarm pin routing codes
  localparam logic [1:0] PIN_SEL_OFF    = 2'h0;
  localparam logic [1:0] PIN_SEL_ALARM  = 2'h1;
  localparam logic [1:0] PIN_SEL_WAKEUP = 2'h3;

  // cycles between a write of 0 to an event flag and the flag dropping
  localparam int CLEAR_DELAY_CYCLES = 2;

  // synchroniser lanes: toggles first, then levels
  localparam int S_SHADOW  = 0;
  localparam int S_WAKEUP  = 1;
  localparam int S_ALARM   = 2;
  localparam int S_SHIFT   = 3;
  localparam int S_RECAL   = 4;
  localparam int S_TAMPER  = 5;
  localparam int S_YEAR    = 8;
  localparam int S_STOPPED = 9;
  localparam int S_WSTOP   = 10;
  localparam int S_HOUR    = 11;
  localparam int S_C512    = 12;
  localparam int S_C1      = 13;
  localparam int EVENT_W   = 8;
  localparam int SYNC_W    = 14;

  // control settings handed to the counter and wakeup units
  typedef struct packed {
    logic       hour_format_sel;
    logic       ratio;
    logic       shadow_bypass;
    logic [2:0] wakeup_clock_select;
    logic       wakeup_timer_enable;
    logic       alarm_enable;
    logic       daylight_saving_memo;
  } ctrl_out_t;

  // decoded wakeup clock source
  typedef struct packed {
    logic       one_second;
    logic       reload_extend;
    logic [4:0] divisor;
  } wakeup_clk_t;

endpackage

/* hdl/rtc_control_status_regs.sv */
// rtc control and status register slice with avalon-mm slave port
// Operation
// - hour format bit: 0 is 24h, 1 AM/PM
// - bypass bit picks shadow or live calendar
// - wakeup select: dividers, one-second, extended reload
// - hour format writable only while init ready
// - wakeup select writable when disabled and permitted
// - enable bits at 6,4,2,0, odd bits zero
// - pin select routes none, alarm or wakeup
// - polarity bit inverts the alarm pin
// - calibration enable drives pin, 512 or 1 Hz
// - subtract hour outside init unless hour zero
// - add hour outside init, reads zero
// - init bit stops counters, raises ready flag
// - shadow sync flag set per copy, cleared
// - calendar initialized flag mirrors year nonzero
// - shift pending set on shift write, hardware-cleared
// - write permission flags after enables cleared; alarm flag is held set while ALARM_WF_ALWAYS is 1, the default
// - recalibration pending set on calibration write
// - wakeup flag set at zero, cleared by 0
// - alarm flag on match, clears two cycles later
// - alarm, wakeup and tamper share one interrupt
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module rtc_control_status_regs
#(
  parameter bit ALARM_WF_ALWAYS = 1'b1      // variant with alarm write flag held set
)
(
  input  wire logic                      CLK,                 // system clock, 50 MHz
  input  wire logic                      RESET_N,             // power-on reset, active low
  input  wire logic [7:0]                ADDRESS,             // byte address
  input  wire logic                      READ,                // read request
  input  wire logic                      WRITE,               // write request
  input  wire logic [31:0]               WRITEDATA,           // write data, low byte used
  input  wire logic [3:0]                BYTEENABLE,          // byte lanes, lane 0 used
  output logic [31:0]                    READDATA,            // read data
  output logic                           WAITREQUEST,         // slave stall
  output logic [1:0]                     RESPONSE,            // okay or decode error
  input  wire logic                      WRITE_UNLOCK,        // key logic opened protection
  input  wire logic                      TAMPER_INT_ENABLE,   // tamper interrupt enable
  input  wire logic                      SHADOW_COPY_TOGGLE,  // calendar copied to shadow
  input  wire logic                      WAKEUP_ZERO_TOGGLE,  // wakeup counter reached zero
  input  wire logic                      ALARM_MATCH_TOGGLE,  // alarm comparator matched
  input  wire logic                      SHIFT_DONE_TOGGLE,   // shift unit finished
  input  wire logic                      RECAL_DONE_TOGGLE,   // new calibration applied
  input  wire logic [2:0]                TAMPER_TOGGLE,       // tamper detections 1..3
  input  wire logic                      YEAR_NONZERO,        // calendar year field not zero
  input  wire logic                      COUNTERS_STOPPED,    // calendar halted for init
  input  wire logic                      WAKEUP_STOPPED,      // wakeup counter idle
  input  wire logic                      HOUR_NONZERO,        // current hour not zero
  input  wire logic                      CAL_CLOCK_512,       // 512 Hz calibration source
  input  wire logic                      CAL_CLOCK_1,         // 1 Hz calibration source
  output rtc_ctrl_pkg::ctrl_out_t        CTRL,                // settings for counter units
  output rtc_ctrl_pkg::wakeup_clk_t      WAKEUP_CLK,          // decoded wakeup clock source
  output logic                           COUNTERS_RUN,        // calendar may count
  output logic                           ADD_HOUR_PULSE,      // one hour forward
  output logic                           SUB_HOUR_PULSE,      // one hour back
  output logic                           SHIFT_START,         // shift low byte written
  output logic [7:0]                     SHIFT_LOW_DATA,      // shift low byte
  output logic                           RECAL_START,         // calibration low byte written
  output logic [7:0]                     CALIB_LOW_DATA,      // calibration low byte
  output logic [6:0]                     SYNC_DIVIDER_HIGH,   // sync divider upper bits
  output logic                           ALARM_PIN,           // routed alarm or wakeup flag
  output logic                           CALIBRATION_CLOCK_PIN, // calibration clock out
  output logic                           IRQ                  // combined interrupt request
);
  import rtc_ctrl_pkg::*;

  // does the bus address hit a given register index
  function automatic logic hit(input logic [7:0] addr, input logic [4:0] idx);
    hit = (addr[7:2] == {1'b0, idx});
  endfunction

  // wakeup clock code to clock source
  function automatic wakeup_clk_t decode_wakeup(input logic [2:0] code);
    decode_wakeup.one_second    = code[2];
    decode_wakeup.reload_extend = code[2] & code[1];
    case (code[1:0])
      2'h0:    decode_wakeup.divisor = 5'h10;
      2'h1:    decode_wakeup.divisor = 5'h08;
      2'h2:    decode_wakeup.divisor = 5'h04;
      default: decode_wakeup.divisor = 5'h02;
    endcase
    if (code[2])
    begin
      decode_wakeup.divisor = 5'h00;
    end
  endfunction

  logic [SYNC_W-1:0]  sync_a;
  logic [SYNC_W-1:0]  sync_b;
  logic [SYNC_W-1:0]  sync_in;
  logic [EVENT_W-1:0] sync_c;
  logic [EVENT_W-1:0] evt;
  logic               wait_q;
  logic               req;
  logic               wr;
  logic [7:0]         wdat;
  logic               wr_prot;
  logic               init_bit;
  logic               initialization_ready_flag;
  logic               shadow_synchronized_flag;
  logic               shift_pending_flag;
  logic               recalibration_pending_flag;
  logic               wakeup_write_permission_flag;
  logic               alarm_write_permission_flag;
  logic               calendar_initialized_flag;
  logic               wakeup_ie;
  logic               alarm_ie;
  logic               cal_out_en;
  logic [1:0]         pin_sel;
  logic               pin_pol;
  logic               cal_freq;
  logic [4:0]         flags;
  logic [4:0]         clr_d1;
  logic [4:0]         clr_d2;
  logic [4:0]         next_flags;
  logic [7:0]         rd_byte;
  logic               rd_mapped;

  // lane order follows the S_ indices; tamper bit 0 lands on lane S_TAMPER
  assign sync_in = {CAL_CLOCK_1, CAL_CLOCK_512, HOUR_NONZERO, WAKEUP_STOPPED,
                    COUNTERS_STOPPED, YEAR_NONZERO, TAMPER_TOGGLE, RECAL_DONE_TOGGLE,
                    SHIFT_DONE_TOGGLE, ALARM_MATCH_TOGGLE, WAKEUP_ZERO_TOGGLE,
                    SHADOW_COPY_TOGGLE};

  // kernel-side inputs cross on two flops; the first stage feeds only the second
  generate
    for (genvar i = 0; i < SYNC_W; i++)
    begin : g_sync
      always_ff @(posedge CLK or negedge RESET_N)
      begin
        if (!RESET_N)
        begin
          sync_a[i] <= 1'b0;
          sync_b[i] <= 1'b0;
        end
        else
        begin
          sync_a[i] <= sync_in[i];
          sync_b[i] <= sync_a[i];
        end
      end
    end
  endgenerate

  // toggle lanes turn into one-cycle event pulses
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      sync_c <= '0;
    else
      sync_c <= sync_b[EVENT_W-1:0];
  end
  assign evt = sync_b[EVENT_W-1:0] ^ sync_c;

  // one wait state per access: data is set up while waitrequest is high
  assign req     = READ | WRITE;
  assign wdat    = WRITEDATA[7:0];
  assign wr      = WRITE & ~wait_q & BYTEENABLE[0];
  assign wr_prot = wr & WRITE_UNLOCK;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      wait_q <= 1'b1;
    else
      wait_q <= ~(req & wait_q);
  end
  assign WAITREQUEST = wait_q;

  // read data and response are captured on the stall cycle and held
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      READDATA <= 32'h00000000;
      RESPONSE <= 2'h0;
    end
    else if (req && wait_q)
    begin
      READDATA <= READ ? {24'h000000, rd_byte} : 32'h00000000;
      RESPONSE <= rd_mapped ? 2'h0 : 2'h3;
    end
  end

  // format and wakeup clock register
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      CTRL.hour_format_sel     <= RST_FORMAT_WAKEUP[BIT_HOUR_FORMAT];
      CTRL.ratio               <= RST_FORMAT_WAKEUP[BIT_RATIO];
      CTRL.shadow_bypass       <= RST_FORMAT_WAKEUP[BIT_BYPASS];
      CTRL.wakeup_clock_select <= RST_FORMAT_WAKEUP[2:0];
    end
    else if (wr_prot && hit(ADDRESS, IDX_FORMAT_WAKEUP))
    begin
      if (initialization_ready_flag)
        CTRL.hour_format_sel <= wdat[BIT_HOUR_FORMAT];
      CTRL.ratio         <= wdat[BIT_RATIO];
      CTRL.shadow_bypass <= wdat[BIT_BYPASS];
      if (!CTRL.wakeup_timer_enable && wakeup_write_permission_flag)
        CTRL.wakeup_clock_select <= wdat[2:0];
    end
  end

  // decoded wakeup source follows the select one cycle later
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      WAKEUP_CLK <= decode_wakeup(RST_FORMAT_WAKEUP[2:0]);
    else
      WAKEUP_CLK <= decode_wakeup(CTRL.wakeup_clock_select);
  end

  // enable register
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      wakeup_ie                <= RST_ENABLE[BIT_WAKEUP_IE];
      alarm_ie                 <= RST_ENABLE[BIT_ALARM_IE];
      CTRL.wakeup_timer_enable <= RST_ENABLE[BIT_WAKEUP_EN];
      CTRL.alarm_enable        <= RST_ENABLE[BIT_ALARM_EN];
    end
    else if (wr_prot && hit(ADDRESS, IDX_ENABLE))
    begin
      wakeup_ie                <= wdat[BIT_WAKEUP_IE];
      alarm_ie                 <= wdat[BIT_ALARM_IE];
      CTRL.wakeup_timer_enable <= wdat[BIT_WAKEUP_EN];
      CTRL.alarm_enable        <= wdat[BIT_ALARM_EN];
    end
  end

  // output and hour adjust register; hour pulses last one cycle
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cal_out_en                <= RST_OUTPUT_HOUR[BIT_CAL_OUT_EN];
      pin_sel                   <= RST_OUTPUT_HOUR[6:5];
      pin_pol                   <= RST_OUTPUT_HOUR[BIT_POLARITY];
      cal_freq                  <= RST_OUTPUT_HOUR[BIT_CAL_FREQ];
      CTRL.daylight_saving_memo <= RST_OUTPUT_HOUR[BIT_DST_MEMO];
      ADD_HOUR_PULSE            <= 1'b0;
      SUB_HOUR_PULSE            <= 1'b0;
    end
    else
    begin
      ADD_HOUR_PULSE <= 1'b0;
      SUB_HOUR_PULSE <= 1'b0;
      if (wr_prot && hit(ADDRESS, IDX_OUTPUT_HOUR))
      begin
        cal_out_en                <= wdat[BIT_CAL_OUT_EN];
        pin_sel                   <= wdat[6:5];
        pin_pol                   <= wdat[BIT_POLARITY];
        cal_freq                  <= wdat[BIT_CAL_FREQ];
        CTRL.daylight_saving_memo <= wdat[BIT_DST_MEMO];
        // software must keep the adjustment inside the current day
        ADD_HOUR_PULSE <= wdat[BIT_ADD_HOUR] & ~init_bit & ~initialization_ready_flag;
        SUB_HOUR_PULSE <= wdat[BIT_SUB_HOUR] & ~init_bit & ~initialization_ready_flag
                          & sync_b[S_HOUR];
      end
    end
  end

  // init request and shadow sync flag; a copy beats a write of 0 but not the clear while init is ready
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      init_bit     <= 1'b0;
      COUNTERS_RUN <= 1'b1;
      shadow_synchronized_flag          <= 1'b0;
    end
    else
    begin
      if (wr_prot && hit(ADDRESS, IDX_INIT_STATUS))
      begin
        init_bit     <= wdat[BIT_INIT];
        COUNTERS_RUN <= ~wdat[BIT_INIT];
      end
      if (initialization_ready_flag)
        shadow_synchronized_flag <= 1'b0;
      else if (evt[S_SHADOW])
        shadow_synchronized_flag <= 1'b1;
      else if (wr_prot && hit(ADDRESS, IDX_INIT_STATUS) && !wdat[BIT_SHADOW_SYNC])
        shadow_synchronized_flag <= 1'b0;
    end
  end

  // status flags that hardware derives from the units
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      initialization_ready_flag  <= 1'b0;
      wakeup_write_permission_flag  <= 1'b0;
      alarm_write_permission_flag <= 1'b0;
      calendar_initialized_flag  <= 1'b0;
    end
    else
    begin
      initialization_ready_flag  <= init_bit & sync_b[S_STOPPED];
      wakeup_write_permission_flag  <= ~CTRL.wakeup_timer_enable & sync_b[S_WSTOP];
      alarm_write_permission_flag <= ALARM_WF_ALWAYS | ~CTRL.alarm_enable;
      calendar_initialized_flag  <= sync_b[S_YEAR];
    end
  end

  // shift request; a pending shift locks out further shift writes
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      shift_pending_flag           <= 1'b0;
      SHIFT_START    <= 1'b0;
      SHIFT_LOW_DATA <= 8'h00;
    end
    else
    begin
      SHIFT_START <= 1'b0;
      if (wr_prot && hit(ADDRESS, IDX_SHIFT_LOW) && !shift_pending_flag)
      begin
        shift_pending_flag           <= 1'b1;
        SHIFT_START    <= 1'b1;
        SHIFT_LOW_DATA <= wdat;
      end
      else if (evt[S_SHIFT])
        shift_pending_flag <= 1'b0;
    end
  end

  // recalibration request; blocked while the previous one is pending
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      recalibration_pending_flag        <= 1'b0;
      RECAL_START    <= 1'b0;
      CALIB_LOW_DATA <= 8'h00;
    end
    else
    begin
      RECAL_START <= 1'b0;
      if (wr_prot && hit(ADDRESS, IDX_CALIB_LOW) && !recalibration_pending_flag)
      begin
        recalibration_pending_flag        <= 1'b1;
        RECAL_START    <= 1'b1;
        CALIB_LOW_DATA <= wdat;
      end
      else if (evt[S_RECAL])
        recalibration_pending_flag <= 1'b0;
    end
  end

  // synchronous divider high part, writable only while init is ready
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      SYNC_DIVIDER_HIGH <= RST_SYNC_DIV_HIGH;
    else if (wr_prot && initialization_ready_flag && hit(ADDRESS, IDX_SYNC_DIV_HIGH))
      SYNC_DIVIDER_HIGH <= wdat[6:0];
  end

  // event flags {tamper3..1, wakeup, alarm}: writing 0 clears two cycles later
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      clr_d1 <= 5'h00;
      clr_d2 <= 5'h00;
    end
    else
    begin
      clr_d1 <= (wr && hit(ADDRESS, IDX_EVENT_FLAG)) ?
                ~{wdat[7:5], wdat[2], wdat[0]} : 5'h00;
      clr_d2 <= clr_d1;
    end
  end

  // set beats a clear landing in the same cycle
  always_comb
  begin
    next_flags = flags & ~clr_d2;
    next_flags = next_flags | {evt[S_TAMPER+2], evt[S_TAMPER+1], evt[S_TAMPER],
                               evt[S_WAKEUP], evt[S_ALARM]};
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      flags <= RST_EVENT_FLAG[4:0];
    else
      flags <= next_flags;
  end

  // pins and interrupt; the disabled pin rests at the inactive level
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ALARM_PIN             <= 1'b0;
      CALIBRATION_CLOCK_PIN <= 1'b0;
      IRQ                   <= 1'b0;
    end
    else
    begin
      ALARM_PIN <= pin_pol ^ ((pin_sel == PIN_SEL_ALARM  && flags[0]) ||
                              (pin_sel == PIN_SEL_WAKEUP && flags[1]));
      CALIBRATION_CLOCK_PIN <= cal_out_en &
                               (cal_freq ? sync_b[S_C1] : sync_b[S_C512]);
      IRQ <= (flags[0] & alarm_ie) | (flags[1] & wakeup_ie)
             | (|flags[4:2] & TAMPER_INT_ENABLE);
    end
  end

  // read mux; odd enable bits and reserved bits read zero
  always_comb
  begin
    rd_byte   = 8'h00;
    rd_mapped = 1'b1;
    case (ADDRESS[7:2])
      {1'b0, IDX_FORMAT_WAKEUP}:
        rd_byte = {1'b0, CTRL.hour_format_sel, CTRL.ratio, CTRL.shadow_bypass,
                   1'b0, CTRL.wakeup_clock_select};
      {1'b0, IDX_ENABLE}:
        rd_byte = {1'b0, wakeup_ie, 1'b0, alarm_ie, 1'b0,
                   CTRL.wakeup_timer_enable, 1'b0, CTRL.alarm_enable};
      {1'b0, IDX_OUTPUT_HOUR}:
        rd_byte = {cal_out_en, pin_sel, pin_pol, cal_freq,
                   CTRL.daylight_saving_memo, 2'h0};
      {1'b0, IDX_INIT_STATUS}:
        rd_byte = {init_bit, initialization_ready_flag, shadow_synchronized_flag, calendar_initialized_flag, shift_pending_flag, wakeup_write_permission_flag, recalibration_pending_flag, alarm_write_permission_flag};
      {1'b0, IDX_EVENT_FLAG}:
        rd_byte = {flags[4:2], 2'h0, flags[1], 1'b0, flags[0]};
      {1'b0, IDX_SYNC_DIV_HIGH}:
        rd_byte = {1'b0, SYNC_DIVIDER_HIGH};
      {1'b0, IDX_SHIFT_LOW},
      {1'b0, IDX_CALIB_LOW}:
        rd_byte = 8'h00;
      default:
        rd_mapped = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

/* verification/rtc_regs_asserts.sv */
// checker: bus handshake, write lock, init, hour pulse and wakeup decode
`timescale 1ns/10ps
`default_nettype none
module rtc_regs_asserts
(
  input wire logic                      CLK,           // clock
  input wire logic                      RESET_N,       // reset
  input wire logic [7:0]                ADDRESS,       // address
  input wire logic                      READ,          // read
  input wire logic                      WRITE,         // write
  input wire logic [31:0]               WRITEDATA,     // data
  input wire logic                      WAITREQUEST,   // stall
  input wire logic                      WRITE_UNLOCK,  // unlock
  input wire rtc_ctrl_pkg::ctrl_out_t   CTRL,          // settings
  input wire rtc_ctrl_pkg::wakeup_clk_t WAKEUP_CLK,    // wakeup source
  input wire logic                      COUNTERS_RUN,  // running
  input wire logic                      ADD_HOUR_PULSE // hour up
);
  import rtc_ctrl_pkg::*;
  logic       acc;
  logic       add_wr;
  logic       sec;
  logic [4:0] div;
  // write taken, hour step asked, wakeup decode expected one cycle on
  assign acc = WRITE && !WAITREQUEST;
  assign add_wr = acc && ADDRESS == 8'h28 && WRITEDATA[0];
  assign sec = CTRL.wakeup_clock_select[2];
  assign div = sec ? 5'h00 : 5'h10 >> CTRL.wakeup_clock_select[1:0];
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  a_one_wait: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("no answer after one wait state");
  a_wait_back: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("wait request low too long");
  a_lock_ctrl: assert property (acc && !WRITE_UNLOCK |=> $stable(CTRL))
    else $error("locked write changed control");
  a_init_stop: assert property (acc && WRITE_UNLOCK && ADDRESS == 8'h30 && WRITEDATA[7]
    |-> ##[1:2] !COUNTERS_RUN) else $error("init did not stop counters");
  a_add_cause: assert property (ADD_HOUR_PULSE |-> $past(add_wr))
    else $error("hour pulse without a write");
  a_add_once: assert property (ADD_HOUR_PULSE |=> !ADD_HOUR_PULSE)
    else $error("hour pulse too long");
  a_wk_second: assert property (WAKEUP_CLK.one_second == $past(sec))
    else $error("wrong wakeup source");
  a_wk_div: assert property (WAKEUP_CLK.divisor == $past(div))
    else $error("wrong wakeup divisor");
endmodule
bind rtc_control_status_regs rtc_regs_asserts i_rtc_regs_asserts
(
  .CLK, .RESET_N, .ADDRESS, .READ, .WRITE, .WRITEDATA, .WAITREQUEST, .WRITE_UNLOCK,
  .CTRL, .WAKEUP_CLK, .COUNTERS_RUN, .ADD_HOUR_PULSE
);
`default_nettype wire

/* verification/test_rtc_control_status_regs.sv */
// testbench: register access, locks, hour steps, events and status flags
`timescale 1ns/10ps
`default_nettype none
module test_rtc_control_status_regs;
  import rtc_ctrl_pkg::*;
  logic        CLK, RESET_N, READ, WRITE, WRITE_UNLOCK, WAITREQUEST, COUNTERS_RUN;
  logic        SHADOW_COPY_TOGGLE, WAKEUP_ZERO_TOGGLE, ALARM_MATCH_TOGGLE, SHIFT_DONE_TOGGLE;
  logic        RECAL_DONE_TOGGLE, YEAR_NONZERO, COUNTERS_STOPPED, WAKEUP_STOPPED;
  logic        HOUR_NONZERO, ADD_HOUR_PULSE, SUB_HOUR_PULSE, ALARM_PIN, IRQ;
  logic        TAMPER_INT_ENABLE, CAL_CLOCK_512, CALIBRATION_CLOCK_PIN, SHIFT_START;
  logic        RECAL_START;
  logic [1:0]  RESPONSE;
  logic [2:0]  TAMPER_TOGGLE;
  logic [6:0]  SYNC_DIVIDER_HIGH;
  logic [7:0]  ADDRESS, rdat, SHIFT_LOW_DATA, CALIB_LOW_DATA;
  logic [31:0] WRITEDATA, READDATA;
  logic [3:0]  BYTEENABLE;
  ctrl_out_t   CTRL;
  wakeup_clk_t WAKEUP_CLK;
  int          miscompares, num_checks;
  rtc_control_status_regs i_rtc_control_status_regs
  (
    .CLK, .RESET_N, .ADDRESS, .READ, .WRITE, .WRITEDATA, .BYTEENABLE, .READDATA,
    .WAITREQUEST, .RESPONSE, .WRITE_UNLOCK, .TAMPER_INT_ENABLE,
    .SHADOW_COPY_TOGGLE, .WAKEUP_ZERO_TOGGLE, .ALARM_MATCH_TOGGLE, .SHIFT_DONE_TOGGLE,
    .RECAL_DONE_TOGGLE, .TAMPER_TOGGLE, .YEAR_NONZERO, .COUNTERS_STOPPED,
    .WAKEUP_STOPPED, .HOUR_NONZERO, .CAL_CLOCK_512, .CAL_CLOCK_1(1'b0), .CTRL,
    .WAKEUP_CLK, .COUNTERS_RUN, .ADD_HOUR_PULSE, .SUB_HOUR_PULSE, .SHIFT_START,
    .SHIFT_LOW_DATA, .RECAL_START, .CALIB_LOW_DATA, .SYNC_DIVIDER_HIGH,
    .ALARM_PIN, .CALIBRATION_CLOCK_PIN, .IRQ
  );
  // one bus transfer; a hung slave is cut short by the watchdog
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    ADDRESS <= a;
    WRITEDATA <= {24'h000000, d};
    BYTEENABLE <= 4'h1;
    WRITE <= w;
    READ <= !w;
    @(posedge CLK);
    while (WAITREQUEST !== 1'b0) @(posedge CLK);
    rdat = READDATA[7:0];
    WRITE <= 1'b0;
    READ <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  // the tests need well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge CLK);
    miscompares++;
    final_report();
  end
  initial
  begin
    {READ, WRITE, ADDRESS, WRITEDATA, BYTEENABLE, SHADOW_COPY_TOGGLE, RESET_N} <= '0;
    {WAKEUP_ZERO_TOGGLE, ALARM_MATCH_TOGGLE, SHIFT_DONE_TOGGLE, RECAL_DONE_TOGGLE} <= '0;
    {YEAR_NONZERO, COUNTERS_STOPPED, TAMPER_TOGGLE, CAL_CLOCK_512} <= '0;
    {WAKEUP_STOPPED, HOUR_NONZERO, WRITE_UNLOCK, TAMPER_INT_ENABLE} <= '1;
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge CLK);
    rd(8'h30, 8'h05);
    rd(8'h24, 8'h00);
    rd(8'h04, 8'h00);
    chk({6'h00, RESPONSE}, 8'h03);
    bus(1'b1, 8'h20, 8'hFF);
    rd(8'h20, 8'h37);
    COUNTERS_STOPPED <= 1'b1;
    bus(1'b1, 8'h30, 8'h80);
    repeat (4) @(posedge CLK);
    rd(8'h30, 8'hC5);
    chk({7'h00, COUNTERS_RUN}, 8'h00);
    bus(1'b1, 8'h40, 8'hA5);
    rd(8'h40, 8'h25);
    chk({1'b0, SYNC_DIVIDER_HIGH}, 8'h25);
    bus(1'b1, 8'h20, 8'hFF);
    rd(8'h20, 8'h77);
    WRITE_UNLOCK <= 1'b0;
    bus(1'b1, 8'h20, 8'h00);
    rd(8'h20, 8'h77);
    WRITE_UNLOCK <= 1'b1;
    $display("reset, init and lock test done");
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, 8'h20, 8'(c));
      @(posedge CLK);
      chk({1'b0, WAKEUP_CLK}, {1'b0, c[2], c[2] & c[1], c[2] ? 5'h00 : 5'h10 >> c[1:0]});
    end
    bus(1'b1, 8'h24, 8'hFF);
    rd(8'h24, 8'h55);
    bus(1'b1, 8'h20, 8'h00);
    rd(8'h20, 8'h07);
    rd(8'h30, 8'hC1);
    $display("wakeup select test done");
    COUNTERS_STOPPED <= 1'b0;
    bus(1'b1, 8'h30, 8'h00);
    bus(1'b1, 8'h24, 8'h40);
    bus(1'b1, 8'h28, 8'h01);
    chk({6'h00, ADD_HOUR_PULSE, COUNTERS_RUN}, 8'h03);
    bus(1'b1, 8'h28, 8'h02);
    chk({7'h00, SUB_HOUR_PULSE}, 8'h01);
    HOUR_NONZERO <= 1'b0;
    repeat (3) @(posedge CLK);
    bus(1'b1, 8'h28, 8'h02);
    chk({7'h00, SUB_HOUR_PULSE}, 8'h00);
    CAL_CLOCK_512 <= 1'b1;
    bus(1'b1, 8'h28, 8'hF0);
    @(posedge CLK);
    chk({7'h00, ALARM_PIN}, 8'h01);
    WAKEUP_ZERO_TOGGLE <= 1'b1;
    repeat (5) @(posedge CLK);
    chk({5'h00, CALIBRATION_CLOCK_PIN, ALARM_PIN, IRQ}, 8'h05);
    WRITE_UNLOCK <= 1'b0;
    bus(1'b1, 8'h34, 8'h00);
    repeat (3) @(posedge CLK);
    rd(8'h34, 8'h00);
    ALARM_MATCH_TOGGLE <= 1'b1;
    TAMPER_TOGGLE <= 3'h4;
    repeat (5) @(posedge CLK);
    rd(8'h34, 8'h81);
    chk({7'h00, IRQ}, 8'h01);
    $display("hour step and event test done");
    WRITE_UNLOCK <= 1'b1;
    YEAR_NONZERO <= 1'b1;
    SHADOW_COPY_TOGGLE <= 1'b1;
    bus(1'b1, 8'h6C, 8'h5A);
    chk({7'h00, SHIFT_START}, 8'h01);
    chk(SHIFT_LOW_DATA, 8'h5A);
    bus(1'b1, 8'h4C, 8'h11);
    chk({7'h00, RECAL_START}, 8'h01);
    chk(CALIB_LOW_DATA, 8'h11);
    rd(8'h30, 8'h3F);
    SHIFT_DONE_TOGGLE <= 1'b1;
    RECAL_DONE_TOGGLE <= 1'b1;
    bus(1'b1, 8'h30, 8'h00);
    repeat (3) @(posedge CLK);
    rd(8'h30, 8'h15);
    $display("status flag test done");
    final_report();
  end
endmodule
`default_nettype wire
